// ==== logic/dnr_pkg.sv ====
package dnr_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_IMPL_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_EXT_DBG     = 8'h04;
  localparam logic [7:0]  OFS_MSW         = 8'h08;
  localparam logic [7:0]  OFS_DBG_PC      = 8'h0C;
  localparam logic [7:0]  OFS_DBG_ST      = 8'h10;
  localparam logic [7:0]  OFS_MC_PC       = 8'h14;
  localparam logic [7:0]  OFS_MC_ST       = 8'h18;
  localparam logic [7:0]  OFS_BASE_PC     = 8'h1C;
  localparam logic [7:0]  OFS_CRIT_PC     = 8'h20;
  localparam logic [7:0]  OFS_SCAN_IR     = 8'h24;
  localparam logic [7:0]  OFS_SCAN_PC     = 8'h28;
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'h2C;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h30;
  localparam logic [7:0]  OFS_HALT_STAT   = 8'h34;

  // Field positions
  localparam int          DFE_BIT         = 0;
  localparam int          NHE_BIT         = 0;
  localparam int          RESUME_BIT      = 1;
  localparam int          IDM_BIT         = 2;
  localparam int          EDM_BIT         = 3;
  localparam int          EXT_W           = 4;
  localparam int          MSW_PR_BIT      = 14;
  localparam int          MSW_EE_BIT      = 15;
  localparam int          MSW_CE_BIT      = 17;
  localparam int          PEND_BASE       = 0;
  localparam int          PEND_CRIT       = 1;
  localparam int          IRQ_HALT        = 0;
  localparam int          IRQ_ILLEGAL     = 1;
  localparam int          IRQ_RETURN      = 2;
  localparam int          IRQ_PRIV        = 3;
  localparam int          IRQ_W           = 4;
  localparam int          REASON_LSB      = 21;
  localparam int          REASON_W        = 5;
  localparam int          HALTED_BIT      = 8;

  // Reset values
  localparam logic [31:0] WORD_RST        = 32'h0000_0000;
  localparam logic [31:0] MSW_RST         = 32'h0000_0000;

  // Instruction encodings
  localparam logic [31:0] XL_MASK         = 32'hFC00_07FE;
  localparam logic [31:0] ENC_DBG_RET     = 32'h4C00_004E;
  localparam logic [31:0] ENC_MC_RET      = 32'h4C00_004C;
  localparam logic [31:0] ENC_NH_FIXED    = 32'h4C00_018C;
  localparam logic [31:0] ENC_NH_LONG_VL  = 32'h7C00_01E0;
  localparam logic [15:0] ENC_DBG_RET_SH  = 16'h000A;
  localparam logic [15:0] ENC_MC_RET_SH   = 16'h000B;
  localparam logic [15:0] ENC_NH_SHORT_VL = 16'h000F;

  typedef enum logic [0:0] {ST_RUN, ST_HALTED} dnr_state_t;
  typedef enum logic [1:0] {CAUSE_ILLEGAL, CAUSE_PRIV, CAUSE_CRIT, CAUSE_BASE} dnr_cause_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] word;
    logic        short_form;
    logic        varlen_page;
  } dnr_ins_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
  } dnr_redir_t;

  typedef struct packed {
    logic        valid;
    dnr_cause_t  cause;
  } dnr_exc_t;

endpackage

// ==== logic/dnr_return_unit.sv ====
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module dnr_return_unit
  import dnr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ins_valid,
  output logic                   ins_ready,
  input  wire dnr_ins_t          ins,
  input  wire logic [1:0]        pend_exc,
  output dnr_redir_t             redir,
  output dnr_exc_t               exc,
  output logic                   ctx_sync,
  output logic                   halted,
  output logic [REASON_W-1:0]    halt_reason,
  output logic                   irq
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0]         impl_ctrl_reg;
  logic [EXT_W-1:0]    ext_dbg_reg;
  logic [31:0]         msw_reg;
  logic [31:0]         dbg_pc_reg;
  logic [31:0]         dbg_st_reg;
  logic [31:0]         mc_pc_reg;
  logic [31:0]         mc_st_reg;
  logic [31:0]         base_pc_reg;
  logic [31:0]         crit_pc_reg;
  logic [31:0]         scan_ir_reg;
  logic [31:0]         scan_pc_reg;
  logic [IRQ_W-1:0]    stat_reg;
  logic [IRQ_W-1:0]    mask_reg;
  logic [31:0]         prdata_reg;
  logic                pslverr_reg;
  logic [REASON_W-1:0] reason_reg;
  dnr_state_t          state_reg;
  dnr_redir_t          redir_reg;
  dnr_exc_t            exc_reg;
  logic                ctx_reg;

  logic                fire;
  logic                wr_en;
  logic                rd_setup;
  logic                dfe;
  logic                nhe;
  logic                is_fixed;
  logic                is_long;
  logic                dec_dret_long;
  logic                dec_dret_short;
  logic                dec_mret_long;
  logic                dec_mret_short;
  logic                dec_nh_fixed;
  logic                dec_nh_long_vl;
  logic                dec_nh_short_vl;
  logic                dec_dret;
  logic                dec_mret;
  logic                any_nh;
  logic                user_mode;
  logic                dret_illegal;
  logic                nh_illegal;
  logic                illegal_go;
  logic                priv_go;
  logic                ret_go;
  logic                halt_go;
  logic                resume_go;
  logic [31:0]         new_msw;
  logic [31:0]         src_pc;
  logic [31:0]         fetch_pc;
  logic                crit_hit;
  logic                base_hit;
  logic [31:0]         rd_mux;
  logic                map_hit;
  logic [IRQ_W-1:0]    events;

  function automatic logic wr_at(input logic [ADDR_W-1:0] ofs);
    return wr_en && (paddr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  assign ins_ready = (state_reg == ST_RUN);
  assign fire      = ins_valid && ins_ready;
  assign dfe       = impl_ctrl_reg[DFE_BIT];
  assign nhe       = ext_dbg_reg[NHE_BIT];
  assign user_mode = msw_reg[MSW_PR_BIT];
  assign is_fixed  = !ins.varlen_page;
  assign is_long   = !ins.short_form;

  assign dec_nh_fixed    = is_fixed && is_long && ((ins.word & XL_MASK) == ENC_NH_FIXED);
  assign dec_nh_long_vl  = !is_fixed && is_long && ((ins.word & XL_MASK) == ENC_NH_LONG_VL);
  assign dec_nh_short_vl = !is_fixed && !is_long && (ins.word[15:0] == ENC_NH_SHORT_VL);
  assign dec_mret_long   = is_fixed && is_long && ((ins.word & XL_MASK) == ENC_MC_RET);
  assign dec_mret_short  = !is_fixed && !is_long && (ins.word[15:0] == ENC_MC_RET_SH);
  assign dec_dret_long   = is_fixed && is_long && ((ins.word & XL_MASK) == ENC_DBG_RET);
  assign dec_dret_short  = !is_fixed && !is_long && (ins.word[15:0] == ENC_DBG_RET_SH);
  assign dec_dret        = dec_dret_long || dec_dret_short;
  assign dec_mret        = dec_mret_long || dec_mret_short;
  assign any_nh          = dec_nh_fixed || dec_nh_long_vl || dec_nh_short_vl;

  // debug returns need the feature enable
  assign dret_illegal = dec_dret && !dfe;
  assign nh_illegal   = any_nh && !nhe;
  assign illegal_go   = fire && (dret_illegal || nh_illegal);
  assign priv_go      = fire && ((dec_dret && dfe) || dec_mret) && user_mode;
  assign ret_go       = fire && ((dec_dret && dfe) || dec_mret) && !user_mode;
  // no privilege term; debug mode bits not consulted
  assign halt_go      = fire && any_nh && nhe;
  assign resume_go    = (state_reg == ST_HALTED) && wr_at(OFS_EXT_DBG) && pwdata[RESUME_BIT];

  assign new_msw  = dec_dret ? dbg_st_reg : mc_st_reg;
  assign src_pc   = dec_dret ? dbg_pc_reg : mc_pc_reg;
  assign crit_hit = pend_exc[PEND_CRIT] && new_msw[MSW_CE_BIT];
  assign base_hit = pend_exc[PEND_BASE] && new_msw[MSW_EE_BIT];

  always_comb begin
    fetch_pc = {dbg_pc_reg[31:1], 1'b0};
    if (dec_dret_short) begin
      // short form uses the same target as the long form: dbg_pc_reg with bit 0 cleared
      fetch_pc = {dbg_pc_reg[31:1], 1'b0};
    end else if (dec_mret) begin
      fetch_pc = {mc_pc_reg[31:1], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Run / halted state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_RUN;
    end else if (halt_go) begin
      state_reg <= ST_HALTED;
    end else if (resume_go) begin
      state_reg <= ST_RUN;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reason_reg <= '0;
    end else if (halt_go) begin
      // reason field of the long forms
      reason_reg <= dec_nh_short_vl ? '0 : ins.word[REASON_LSB +: REASON_W];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scan_ir_reg <= WORD_RST;
      scan_pc_reg <= WORD_RST;
    end else if (halt_go) begin
      scan_ir_reg <= ins.word;
      scan_pc_reg <= ins.pc;
    end else begin
      if (wr_at(OFS_SCAN_IR)) begin
        scan_ir_reg <= pwdata;
      end
      if (wr_at(OFS_SCAN_PC)) begin
        scan_pc_reg <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Return and exception results
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      msw_reg <= MSW_RST;
    end else if (ret_go) begin
      msw_reg <= new_msw;
    end else if (wr_at(OFS_MSW)) begin
      msw_reg <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      redir_reg <= '0;
    end else begin
      redir_reg.valid <= (ret_go && !crit_hit && !base_hit) || resume_go;
      // resume continues at the rewritten scan address
      redir_reg.pc    <= resume_go ? scan_pc_reg : fetch_pc;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exc_reg <= '0;
    end else begin
      exc_reg.valid <= illegal_go || priv_go || (ret_go && (crit_hit || base_hit));
      if (illegal_go) begin
        exc_reg.cause <= CAUSE_ILLEGAL;
      end else if (priv_go) begin
        exc_reg.cause <= CAUSE_PRIV;
      end else if (crit_hit) begin
        exc_reg.cause <= CAUSE_CRIT;
      end else begin
        exc_reg.cause <= CAUSE_BASE;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_pc_reg <= WORD_RST;
    end else if (illegal_go || priv_go) begin
      // trapping address kept for the handler
      base_pc_reg <= ins.pc;
    end else if (ret_go && base_hit && !crit_hit) begin
      base_pc_reg <= src_pc;
    end else if (wr_at(OFS_BASE_PC)) begin
      base_pc_reg <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crit_pc_reg <= WORD_RST;
    end else if (ret_go && crit_hit) begin
      crit_pc_reg <= src_pc;
    end else if (wr_at(OFS_CRIT_PC)) begin
      crit_pc_reg <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctx_reg <= 1'b0;
    end else begin
      ctx_reg <= ret_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      impl_ctrl_reg <= WORD_RST;
      ext_dbg_reg   <= '0;
      dbg_pc_reg    <= WORD_RST;
      dbg_st_reg    <= WORD_RST;
      mc_pc_reg     <= WORD_RST;
      mc_st_reg     <= WORD_RST;
      mask_reg      <= '0;
    end else begin
      if (wr_at(OFS_IMPL_CTRL)) begin
        impl_ctrl_reg <= {31'h0000_0000, pwdata[DFE_BIT]};
      end
      if (wr_at(OFS_EXT_DBG)) begin
        ext_dbg_reg <= pwdata[EXT_W-1:0] & ~(4'h1 << RESUME_BIT);
      end
      if (wr_at(OFS_DBG_PC)) begin
        dbg_pc_reg <= pwdata;
      end
      if (wr_at(OFS_DBG_ST)) begin
        dbg_st_reg <= pwdata;
      end
      if (wr_at(OFS_MC_PC)) begin
        mc_pc_reg <= pwdata;
      end
      if (wr_at(OFS_MC_ST)) begin
        mc_st_reg <= pwdata;
      end
      if (wr_at(OFS_IRQ_MASK)) begin
        mask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  assign events = {priv_go, ret_go, illegal_go, halt_go};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(wr_at(OFS_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0)) | events;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data latched in the setup cycle
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  always_comb begin
    rd_mux  = 32'h0000_0000;
    map_hit = 1'b1;
    unique case (paddr)
      OFS_IMPL_CTRL: rd_mux = impl_ctrl_reg;
      OFS_EXT_DBG:   rd_mux = {28'h000_0000, ext_dbg_reg};
      OFS_MSW:       rd_mux = msw_reg;
      OFS_DBG_PC:    rd_mux = dbg_pc_reg;
      OFS_DBG_ST:    rd_mux = dbg_st_reg;
      OFS_MC_PC:     rd_mux = mc_pc_reg;
      OFS_MC_ST:     rd_mux = mc_st_reg;
      OFS_BASE_PC:   rd_mux = base_pc_reg;
      OFS_CRIT_PC:   rd_mux = crit_pc_reg;
      OFS_SCAN_IR:   rd_mux = scan_ir_reg;
      OFS_SCAN_PC:   rd_mux = scan_pc_reg;
      OFS_IRQ_STAT:  rd_mux = {28'h000_0000, stat_reg};
      OFS_IRQ_MASK:  rd_mux = {28'h000_0000, mask_reg};
      OFS_HALT_STAT: rd_mux = {23'h00_0000, (state_reg == ST_HALTED), 3'h0, reason_reg};
      default:       map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (rd_setup) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= !map_hit;
    end
  end

  assign prdata      = prdata_reg;
  assign pslverr     = pslverr_reg;
  assign pready      = 1'b1;
  assign redir       = redir_reg;
  assign exc         = exc_reg;
  assign ctx_sync    = ctx_reg;
  assign halted      = (state_reg == ST_HALTED);
  assign halt_reason = reason_reg;
  assign irq         = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_dret_clean;
    fire && dec_dret && dfe && !user_mode && !crit_hit && !base_hit;
  endsequence

  sequence s_nh_halt;
    fire && any_nh && nhe;
  endsequence

  chk_dret_state_load: assert property (s_dret_clean |=> msw_reg == $past(dbg_st_reg))
    else $error("debug return did not restore state");
  chk_dret_long_pc: assert property (s_dret_clean and dec_dret_long
    |=> redir.valid && redir.pc == {$past(dbg_pc_reg[31:1]), 1'b0})
    else $error("long debug return target wrong");
  chk_dret_short_pc: assert property (s_dret_clean and dec_dret_short
    |=> redir.valid && redir.pc[0] == 1'b0 && redir.pc[31:1] == $past(dbg_pc_reg[31:1]))
    else $error("short debug return target wrong");
  chk_dret_pend_exc: assert property (fire && dec_dret && dfe && !user_mode && base_hit && !crit_hit
    |=> exc.valid && exc.cause == CAUSE_BASE && !redir.valid
        && base_pc_reg == $past(dbg_pc_reg))
    else $error("pending exception after debug return mishandled");
  chk_priv_return: assert property (fire && ((dec_dret && dfe) || dec_mret) && user_mode
    |=> exc.valid && exc.cause == CAUSE_PRIV && $stable(msw_reg) && !ctx_sync)
    else $error("user-mode return not refused");
  chk_dret_disabled: assert property (fire && dec_dret && !dfe
    |=> exc.valid && exc.cause == CAUSE_ILLEGAL && !redir.valid)
    else $error("disabled debug return not illegal");
  chk_nh_halts: assert property (s_nh_halt |=> halted && !ins_ready ##1 halted)
    else $error("notify-halt did not halt");
  chk_nh_reason: assert property (s_nh_halt and (dec_nh_fixed || dec_nh_long_vl)
    |=> halt_reason == $past(ins.word[REASON_LSB +: REASON_W]))
    else $error("halt reason not presented");
  chk_nh_illegal: assert property (fire && any_nh && !nhe
    |=> exc.valid && exc.cause == CAUSE_ILLEGAL && !halted
        && base_pc_reg == $past(ins.pc))
    else $error("disabled notify-halt not trapped");
  chk_nh_user: assert property (s_nh_halt and user_mode |=> halted && !exc.valid)
    else $error("notify-halt privilege checked");
  chk_scan_capture: assert property (s_nh_halt
    |=> scan_ir_reg == $past(ins.word) && scan_pc_reg == $past(ins.pc))
    else $error("scan register not captured");
  chk_page_gate: assert property (fire && !ins.varlen_page && !ins.short_form
    && ((ins.word & XL_MASK) == ENC_NH_LONG_VL) |=> !halted && !exc.valid)
    else $error("variable-length notify-halt decoded in fixed page");
  chk_mret_pc: assert property (fire && dec_mret_long && !user_mode && !crit_hit && !base_hit
    |=> redir.valid && redir.pc == {$past(mc_pc_reg[31:1]), 1'b0}
        && msw_reg == $past(mc_st_reg))
    else $error("machine-check return wrong");
  chk_mret_crit: assert property (fire && dec_mret && !user_mode && crit_hit
    |=> exc.cause == CAUSE_CRIT && crit_pc_reg == $past(mc_pc_reg))
    else $error("critical exception after machine-check return mishandled");
  chk_mret_page: assert property (fire && ins.varlen_page && !ins.short_form
    && ((ins.word & XL_MASK) == ENC_MC_RET) |=> !ctx_sync && !redir.valid)
    else $error("machine-check return decoded in variable page");

endmodule

// ==== verif/dnr_debug_host.sv ====
`timescale 1ns/1ps
module dnr_debug_host
  import dnr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        halted,
  input  wire logic [31:0] scan_pc,
  input  wire logic        scan_short,
  output logic             resume_req,
  output logic [31:0]      resume_pc
);
  logic [1:0] wait_reg;
  // resume past instruction
  // Resume address is recomputed every cycle; the bench waits for it to settle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_reg   <= 2'h0;
      resume_req <= 1'b0;
      resume_pc  <= 32'h0;
    end else begin
      wait_reg   <= halted ? wait_reg + 2'h1 : 2'h0;
      resume_req <= halted && (wait_reg == 2'h3);
      resume_pc  <= scan_pc + (scan_short ? 32'h2 : 32'h4);
    end
  end
endmodule

// ==== verif/debug_mcheck_return_and_notify_halt_tb.sv ====
`timescale 1ns/1ps
module debug_mcheck_return_and_notify_halt_tb
  import dnr_pkg::*;
;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, ins_valid = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, p, sv, st, fw, host_pc, resume_pc;
  logic pready, pslverr, er, ins_ready, ctx_sync, halted, irq, sc, fs, fv, host_sh, resume_req;
  logic [1:0] pend_exc = 2'h0;
  logic [4:0] halt_reason, r;
  dnr_ins_t ins = '0;
  dnr_redir_t redir, sr;
  dnr_exc_t exc, se;
  int failures = 0, checks_done = 0, cyc = 0;
  logic [31:0] seed = 32'h3;
  always #10 clk = ~clk;
  dnr_return_unit i_dnr_return_unit (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ins_valid(ins_valid), .ins_ready(ins_ready), .ins(ins),
    .pend_exc(pend_exc), .redir(redir), .exc(exc), .ctx_sync(ctx_sync), .halted(halted),
    .halt_reason(halt_reason), .irq(irq));
  dnr_debug_host i_dnr_debug_host (.clk(clk), .nrst(nrst), .halted(halted),
    .scan_pc(host_pc), .scan_short(host_sh), .resume_req(resume_req), .resume_pc(resume_pc));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic fire(input logic [31:0] w, input logic sh, input logic vl);
    @(posedge clk);
    ins_valid <= 1; ins <= {p, w, sh, vl};
    @(posedge clk);
    ins_valid <= 0;
    #1;
    sr = redir; se = exc; sc = ctx_sync;
  endtask
  task automatic form(input int k);
    fw = k == 0 ? ENC_NH_FIXED : k == 1 ? ENC_NH_LONG_VL : {16'h0, ENC_NH_SHORT_VL};
    fs = k == 2;
    fv = k != 0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    rdchk(OFS_MSW, MSW_RST); rdchk(OFS_IMPL_CTRL, WORD_RST); rdchk(OFS_EXT_DBG, WORD_RST);
    apb(0, 8'h3C, 32'h0); chk(er, 1);
    apb(1, OFS_IRQ_MASK, 32'h1 << IRQ_ILLEGAL);
    p = xs() & 32'hFFFF_FFFC;
    fire(ENC_DBG_RET, 0, 0); chk(32'(se), {29'h0, 1'b1, CAUSE_ILLEGAL});
    chk(irq, 1); apb(1, OFS_IRQ_STAT, 32'h1 << IRQ_ILLEGAL);
    #1;
    chk(irq, 0);
    apb(1, OFS_IMPL_CTRL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      sv = xs();
      st = xs() & 32'hFFFD_3FFF;
      p = xs() & 32'hFFFF_FFFC;
      fw = i[2] ? (i[1] ? ENC_MC_RET_SH : ENC_MC_RET) : (i[1] ? ENC_DBG_RET_SH : ENC_DBG_RET);
      apb(1, i[2] ? OFS_MC_PC : OFS_DBG_PC, sv);
      if (i[0]) st = st | (i[1] ? 32'h0002_8000 : 32'h0000_8000);
      pend_exc <= i[0] ? {i[1], 1'b1} : 2'(xs());
      apb(1, i[2] ? OFS_MC_ST : OFS_DBG_ST, st);
      fire(fw, i[1], i[1]);
      if (i[0]) begin
        chk(32'(se), {29'h0, 1'b1, i[1] ? CAUSE_CRIT : CAUSE_BASE});
        rdchk(i[1] ? OFS_CRIT_PC : OFS_BASE_PC, sv);
      end else begin
        chk(sr.pc, {sv[31:1], 1'b0}); chk(sr.valid & sc, 1);
      end
      rdchk(OFS_MSW, st);
      apb(1, OFS_MSW, 32'h0);
    end
    fire(ENC_MC_RET, 0, 1); chk({sr.valid, se.valid, sc}, 0);
    apb(1, OFS_MSW, 32'h1 << MSW_PR_BIT);
    fire(ENC_DBG_RET, 0, 0); chk(32'(se), {29'h0, 1'b1, CAUSE_PRIV});
    for (int k = 0; k < 3; k++) begin
      form(k);
      p = xs() & 32'hFFFF_FFFE;
      fire(fw, fs, fv); chk(32'(se), {29'h0, 1'b1, CAUSE_ILLEGAL});
      rdchk(OFS_BASE_PC, p);
    end
    for (int k = 0; k < 3; k++) begin
      apb(1, OFS_EXT_DBG, 32'h1 | ((k + 1) << IDM_BIT));
      form(k);
      r = 5'(xs());
      if (!fs) fw = fw | (32'(r) << REASON_LSB);
      p = xs() & 32'hFFFF_FFFE;
      fire(fw, fs, fv); chk(halted & ~ins_ready, 1);
      chk(32'(halt_reason), fs ? 32'h0 : 32'(r));
      rdchk(OFS_SCAN_IR, fw); rdchk(OFS_SCAN_PC, p);
      host_pc = rd; host_sh = fs;
      // Two edges let the host's registered resume address follow the new scan pc
      repeat (2) @(posedge clk);
      while (resume_req !== 1'b1) begin
        @(posedge clk);
      end
      apb(1, OFS_SCAN_PC, resume_pc);
      apb(1, OFS_EXT_DBG, 32'h3);
      #1;
      chk(redir.valid, 1);
      chk(redir.pc, p + (fs ? 32'h2 : 32'h4)); chk(halted, 0);
    end
    fire(ENC_NH_FIXED, 0, 1); chk({halted, se.valid}, 0);
    fire(ENC_NH_LONG_VL, 0, 0); chk({halted, se.valid}, 0);
    end_sim();
  end
endmodule
